// [rtl/lce_top.sv]
// Purpose: enable and superimposed-operation control of a presence light controller
// Assumes: presence is a pin, telegram pulses and brightness are on mclk
// Notes:   APB answers with zero wait states; read data registered in setup
//
// Overview of operation
// - ending disable resets to off, aborts step-down
// - no-telegram mode: stay off, wait new presence
// - switch-off mode sends off, restarts on presence
// - startup mode sets artificial presence, starts when dark
// - after startup go main, follow real presence
// - four listening inputs when superimposed allowed
// - any listened telegram disables automatic control
// - superimposed off: listening inputs do not act
// - disabling-input-only end waits for enabling telegram
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lce_top (
   input  wire logic                       mclk,       // system clock, 50 MHz
   input  wire logic                       rstn,       // async reset, low
   input  wire logic                       psel,       // apb select
   input  wire logic                       penable,    // apb access phase
   input  wire logic                       pwrite,     // apb direction
   input  wire logic [7:0]                 paddr,      // apb byte address
   input  wire logic [31:0]                pwdata,     // apb write data
   output logic [31:0]                     prdata,     // apb read data
   output logic                            pready,     // apb ready
   output logic                            pslverr,    // apb error
   input  wire logic                       presence,   // presence pin, async
   input  wire logic [7:0]                 bright,     // measured brightness
   input  wire logic [7:0]                 fb_bright,  // actuator feedback
   input  wire logic                       dis_valid,  // disabling telegram
   input  wire logic                       dis_value,  // 1 disable, 0 enable
   input  wire logic [lce_pkg::SO_NUM-1:0] so_tel,     // listening telegrams
   output logic [2:0]                      phase,      // control phase
   output logic                            ctl_on,     // lighting requested
   output logic                            sw_off,     // off command pulse
   output logic                            art_pres    // artificial presence
);
   import lce_pkg::*;

   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      lce_state_e st;         // control phase
      logic [7:0] cnt;        // phase timer
      logic       art;        // artificial presence
      logic       sup;        // disabled by superimposed op
      logic       wait_new;   // need fresh presence first
      logic       off_p;      // off command pulse
      logic       p1;         // presence sync stage one
      logic       p2;         // presence sync stage two
      logic       p3;         // previous synced presence
      logic [3:0] cfg;        // mode, sup enable, sup end
      logic [7:0] setpt;      // brightness setpoint
      logic [7:0] fb;         // last feedback value
      logic [31:0] rdata;     // apb read data
   } lce_top_s;
   lce_top_s s_q;             // state register
   lce_top_s s_d;             // next state
   logic       sup_hit;       // listened telegram, registered
   logic [3:0] seen;          // sticky seen flags
   logic [3:0] seen_clr;      // clear mask from software
   logic       wr;            // apb write at this edge
   logic       rd_setup;      // apb read setup cycle
   logic       en_evt;        // enabling telegram while disabled
   logic       dis_evt;       // disabling telegram
   logic       dark;          // measured below setpoint
   logic [1:0] mode;          // end-of-disabling mode

   // decode of one register address
   function automatic logic lce_dec(input logic [7:0] a, input logic [7:0] off);
      lce_dec = (a == off);
   endfunction : lce_dec

   // ************************************************
   // listening inputs
   // ************************************************
   lce_listen lce_listen_i (
      .mclk   (mclk),
      .rstn   (rstn),
      .en     (s_q.cfg[CFG_SUP_EN]),
      .tel_in (so_tel),
      .clr    (seen_clr),
      .hit    (sup_hit),
      .seen   (seen)
   );

   // ************************************************
   // apb slave
   // ************************************************
   assign pready   = 1'b1;
   assign wr       = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   // unmapped addresses get an error answer and no effect
   assign pslverr  = psel & penable & ~(lce_dec(paddr, ADDR_CFG)
                     | lce_dec(paddr, ADDR_SETPT) | lce_dec(paddr, ADDR_STAT));
   assign seen_clr = (wr && lce_dec(paddr, ADDR_STAT)) ?
                     pwdata[STAT_SEEN_LSB +: 4] : 4'h0;
   assign prdata   = s_q.rdata;

   // ************************************************
   // control helpers
   // ************************************************
   assign mode    = s_q.cfg[CFG_MODE_LSB +: 2];
   assign dark    = bright < s_q.setpt;
   assign dis_evt = dis_valid & dis_value;
   assign en_evt  = dis_valid & ~dis_value & (s_q.st == LCE_DIS);

   // next-state logic of control and registers
   always_comb begin
      s_d       = s_q;
      s_d.off_p = 1'b0;
      // two flops before anyone looks at the pin
      s_d.p1    = presence;
      s_d.p2    = s_q.p1;
      s_d.p3    = s_q.p2;
      s_d.fb    = fb_bright;
      if (!s_q.p2) begin
         s_d.wait_new = 1'b0;                   // presence gone, next one is new
      end
      case (s_q.st)
         LCE_OFF: begin
            if ((s_q.p2 && !s_q.wait_new) || s_q.art) begin
               if (dark) begin
                  s_d.st  = LCE_STARTUP;
                  s_d.cnt = STARTUP_CYC - 8'h01;
               end else if (s_q.p2 && !s_q.wait_new) begin
                  s_d.st  = LCE_MAIN;
                  s_d.art = 1'b0;
               end
            end
         end
         LCE_STARTUP: begin
            if (s_q.cnt == 8'h00) begin
               s_d.st  = LCE_MAIN;
               s_d.art = 1'b0;
            end else begin
               s_d.cnt = s_q.cnt - 8'h01;
            end
         end
         LCE_MAIN: begin
            // only real presence matters from here
            if (!s_q.p2) begin
               s_d.st  = LCE_STEP;
               s_d.cnt = STEP_CYC - 8'h01;
            end
         end
         LCE_STEP: begin
            if (s_q.p2) begin
               s_d.st = LCE_MAIN;
            end else if (s_q.cnt == 8'h00) begin
               s_d.st = LCE_OFF;
            end else begin
               s_d.cnt = s_q.cnt - 8'h01;
            end
         end
         LCE_DIS: begin
            if (en_evt) begin
               // basic state: off, no presence, pending reactions dropped
               s_d.st       = LCE_OFF;
               s_d.cnt      = 8'h00;
               s_d.art      = 1'b0;
               s_d.sup      = 1'b0;
               s_d.wait_new = 1'b0;
               case (mode)
                  END_SWOFF: s_d.off_p    = 1'b1;
                  END_START: s_d.art      = 1'b1;
                  default:   s_d.wait_new = 1'b1;
               endcase
            end else if (s_q.sup && !s_q.cfg[CFG_SUP_END] && s_q.p3 && !s_q.p2) begin
               // end of tracked presence releases superimposed op
               s_d.st  = LCE_STEP;
               s_d.cnt = STEP_CYC - 8'h01;
               s_d.sup = 1'b0;
            end
         end
         default: begin
            s_d.st = LCE_OFF;
         end
      endcase
      // disabling and listening take over any running phase
      if (s_q.st != LCE_DIS) begin
         if (dis_evt) begin
            s_d.st  = LCE_DIS;
            s_d.sup = 1'b0;
            s_d.art = 1'b0;
         end else if (sup_hit) begin
            s_d.st  = LCE_DIS;
            s_d.sup = 1'b1;
            s_d.art = 1'b0;
         end
      end
      // register writes; mode is only changed by software
      if (wr && lce_dec(paddr, ADDR_CFG)) begin
         s_d.cfg = pwdata[3:0];
      end
      if (wr && lce_dec(paddr, ADDR_SETPT)) begin
         s_d.setpt = pwdata[7:0];
      end
      // read data captured in setup, shown in the access cycle
      if (rd_setup) begin
         s_d.rdata = 32'h0;
         if (lce_dec(paddr, ADDR_CFG)) begin
            s_d.rdata[3:0] = s_q.cfg;
         end else if (lce_dec(paddr, ADDR_SETPT)) begin
            s_d.rdata[7:0] = s_q.setpt;
         end else if (lce_dec(paddr, ADDR_STAT)) begin
            s_d.rdata[2:0]                = s_q.st;
            s_d.rdata[STAT_ART]           = s_q.art;
            s_d.rdata[STAT_SUP]           = s_q.sup;
            s_d.rdata[STAT_DIS]           = (s_q.st == LCE_DIS);
            s_d.rdata[STAT_SEEN_LSB +: 4] = seen;
            s_d.rdata[23:16]              = s_q.fb;
         end
      end
   end

   // state register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q       <= '0;
         s_q.st    <= LCE_OFF;
         s_q.cfg   <= CFG_RST;
         s_q.setpt <= SETPT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   assign phase    = s_q.st;
   assign ctl_on   = (s_q.st == LCE_STARTUP) | (s_q.st == LCE_MAIN) | (s_q.st == LCE_STEP);
   assign sw_off   = s_q.off_p;
   assign art_pres = s_q.art;

   // ************************************************
   // checks
   // ************************************************
   end_reset_a: assert property (@(posedge mclk) disable iff (!rstn)
      en_evt |=> (phase == LCE_OFF) && !ctl_on)
      else $error("enable did not return to basic state");
   notel_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
      (en_evt && mode != END_SWOFF && mode != END_START)
      |=> !sw_off && !art_pres && !ctl_on)
      else $error("no-telegram enable changed lighting");
   swoff_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
      (en_evt && mode == END_SWOFF) |=> sw_off ##1 !sw_off)
      else $error("switch-off enable sent no single off");
   startup_art_a: assert property (@(posedge mclk) disable iff (!rstn)
      (en_evt && mode == END_START) |=> art_pres && phase == LCE_OFF)
      else $error("startup enable gave no artificial presence");
   art_dark_a: assert property (@(posedge mclk) disable iff (!rstn)
      (phase == LCE_OFF && art_pres && dark && !dis_evt && !sup_hit)
      |=> phase == LCE_STARTUP)
      else $error("artificial presence did not start up");
   startup_main_a: assert property (@(posedge mclk) disable iff (!rstn)
      (phase == LCE_STARTUP && s_q.cnt == 8'h00 && !dis_evt && !sup_hit)
      |=> phase == LCE_MAIN && !art_pres)
      else $error("startup did not hand over to main");
   sup_disable_a: assert property (@(posedge mclk) disable iff (!rstn)
      (sup_hit && phase != LCE_DIS && !dis_evt) |=> phase == LCE_DIS && s_q.sup)
      else $error("listened telegram did not disable control");
   dis_only_a: assert property (@(posedge mclk) disable iff (!rstn)
      (phase == LCE_DIS && s_q.sup && s_q.cfg[CFG_SUP_END] && !en_evt)
      |=> phase == LCE_DIS)
      else $error("superimposed op ended without enabling telegram");
   mode_static_a: assert property (@(posedge mclk) disable iff (!rstn)
      !(wr && lce_dec(paddr, ADDR_CFG)) |=> $stable(mode))
      else $error("end mode changed without a write");
endmodule : lce_top
`default_nettype wire

// [rtl/lce_pkg.sv]
// Purpose: shared constants and types of the light control enable/override block
// Assumes: 50 MHz mclk, APB register access with 32-bit data
// Notes:   one aligned word per register; unmapped addresses answer with pslverr
package lce_pkg;
   // ************************************************
   // register map and fields
   // ************************************************
   localparam logic [7:0]  ADDR_CFG      = 8'h00;  // configuration word
   localparam logic [7:0]  ADDR_SETPT    = 8'h04;  // brightness setpoint
   localparam logic [7:0]  ADDR_STAT     = 8'h08;  // status, seen flags w1c
   localparam int          CFG_MODE_LSB  = 0;      // end-of-disabling mode, 2 bits
   localparam int          CFG_SUP_EN    = 2;      // superimposed operation allowed
   localparam int          CFG_SUP_END   = 3;      // 1: end only via disabling input
   localparam int          STAT_ART      = 4;      // artificial presence active
   localparam int          STAT_SUP      = 5;      // superimposed operation active
   localparam int          STAT_DIS      = 6;      // control disabled
   localparam int          STAT_SEEN_LSB = 8;      // seen flags of the four inputs
   localparam logic [3:0]  CFG_RST       = 4'h0;   // reset value of cfg bits
   localparam logic [7:0]  SETPT_RST     = 8'h80;  // reset value of setpoint
   // ************************************************
   // end-of-disabling modes
   // ************************************************
   localparam logic [1:0]  END_NOTEL     = 2'h0;   // enable, send nothing
   localparam logic [1:0]  END_SWOFF     = 2'h1;   // enable and switch off
   localparam logic [1:0]  END_START     = 2'h2;   // enable with startup
   // ************************************************
   // listening inputs and timing
   // ************************************************
   localparam int          SO_NUM        = 4;      // switch, dim, value, scene
   localparam int          CLK_NS        = 20;     // mclk period
   localparam int          STARTUP_NS    = 1000;   // startup phase length
   localparam int          STEP_NS       = 2000;   // step-down phase length
   localparam logic [7:0]  STARTUP_CYC   = 8'((STARTUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0]  STEP_CYC      = 8'((STEP_NS + CLK_NS - 1) / CLK_NS);
   typedef enum logic [2:0] {
      LCE_OFF, LCE_STARTUP, LCE_MAIN, LCE_STEP, LCE_DIS
   } lce_state_e;                                  // control phases
endpackage : lce_pkg

// [rtl/lce_listen.sv]
// Purpose: listening inputs for superimposed operation
// Assumes: valid pulses come from bus logic on mclk, so no synchroniser
// Notes:   hit is one cycle behind the telegram; seen flags are sticky
`timescale 1ns/1ps
`default_nettype none
module lce_listen (
   input  wire logic                      mclk,      // system clock
   input  wire logic                      rstn,      // async reset, low
   input  wire logic                      en,        // superimposed op allowed
   input  wire logic [lce_pkg::SO_NUM-1:0] tel_in,   // telegram pulses
   input  wire logic [lce_pkg::SO_NUM-1:0] clr,      // clear seen flags
   output logic                           hit,       // any telegram heard
   output logic [lce_pkg::SO_NUM-1:0]     seen       // sticky seen flags
);
   import lce_pkg::*;
   typedef struct packed {
      logic              any;    // registered hit
      logic [SO_NUM-1:0] seen;   // sticky flags
   } lce_ls_s;
   lce_ls_s s_q;                 // state
   lce_ls_s s_d;                 // next state
   logic [SO_NUM-1:0] gated;     // inputs after enable gate

   // ************************************************
   // per-input gating and flags
   // ************************************************
   genvar gi;
   generate
      for (gi = 0; gi < SO_NUM; gi++) begin : g_in
         // disabled inputs simply do not exist for the control
         assign gated[gi] = en & tel_in[gi];
      end
   endgenerate

   // next state: a new telegram beats a clear in the same cycle
   always_comb begin
      s_d      = s_q;
      s_d.any  = |gated;
      s_d.seen = (s_q.seen & ~clr) | gated;
   end

   // state register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hit  = s_q.any;
   assign seen = s_q.seen;

   gate_off_a: assert property (@(posedge mclk) disable iff (!rstn)
      !en |=> !hit) else $error("telegram heard while listening is off");
   seen_set_a: assert property (@(posedge mclk) disable iff (!rstn)
      (en && tel_in != 0) |=> ((seen & $past(tel_in)) == $past(tel_in)) && hit)
      else $error("listening input did not register telegram");
endmodule : lce_listen
`default_nettype wire

// [testbench/lce_bus_model.sv]
// Purpose: bus side model: pushbuttons, panels, actuator feedback, presence pin
// Assumes: telegram pulses are one mclk cycle wide, launched after a rising edge
// Notes:   qualifiers are scrambled after a pulse so stale values never help
`timescale 1ns/1ps
`default_nettype none
module lce_bus_model (
   input  wire logic                       mclk,       // system clock
   output logic                            presence,   // presence pin level
   output logic [7:0]                      bright,     // measured brightness
   output logic [7:0]                      fb_bright,  // actuator feedback
   output logic                            dis_valid,  // disabling telegram
   output logic                            dis_value,  // 1 disable, 0 enable
   output logic [lce_pkg::SO_NUM-1:0]      so_tel      // listening telegrams
);
   import lce_pkg::*;
   // ************************************************
   // idle levels
   // ************************************************
   initial begin
      presence  = 1'b0;
      bright    = 8'h10;
      fb_bright = 8'h00;
      dis_valid = 1'b0;
      dis_value = 1'b1;
      so_tel    = '0;
   end
   // ************************************************
   // telegram and environment tasks
   // ************************************************
   // disabling telegram; value inverted afterwards, it is meaningless then
   task automatic send_dis(input logic v);
      @(posedge mclk);
      dis_valid <= 1'b1;
      dis_value <= v;
      @(posedge mclk);
      dis_valid <= 1'b0;
      dis_value <= ~v;
   endtask : send_dis
   // a manual button also reports its command to the listening inputs
   task automatic send_so(input int idx);
      @(posedge mclk);
      so_tel <= SO_NUM'(1) << idx;
      @(posedge mclk);
      so_tel <= '0;
   endtask : send_so
   // room state; feedback mirrors the channel one actuator level
   task automatic set_env(input logic p, input logic [7:0] b,
                          input logic [7:0] f);
      @(posedge mclk);
      presence  <= p;
      bright    <= b;
      fb_bright <= f;
   endtask : set_env
endmodule : lce_bus_model
`default_nettype wire

// [testbench/light_control_enable_override_bench.sv]
// Purpose: self-checking bench of the enable and override control block
// Assumes: zero wait APB, one clock at 50 MHz
// Notes:   phase waits are bounded; a stuck phase shows as a mismatch
`timescale 1ns/1ps
`default_nettype none
module light_control_enable_override_bench;
   import lce_pkg::*;
   logic                mclk, rstn, psel, penable, pwrite;  // clock, reset, apb
   logic [7:0]          paddr;                              // apb address
   logic [31:0]         pwdata, prdata;                     // apb data
   logic                pready, pslverr;                    // apb answer
   logic                presence, dis_valid, dis_value;     // model outputs
   logic [7:0]          bright, fb_bright;                  // brightness
   logic [SO_NUM-1:0]   so_tel;                             // listening pulses
   logic [2:0]          phase;                              // control phase
   logic                ctl_on, sw_off, art_pres;           // control outputs
   int                  n_mismatch  = 0;                    // failed compares
   int                  checks_done = 0;                    // all compares
   int                  cyc         = 0;                    // timeout count
   int                  i;                                  // loop index
   lce_top lce_top_i (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .presence(presence), .bright(bright),
      .fb_bright(fb_bright), .dis_valid(dis_valid), .dis_value(dis_value),
      .so_tel(so_tel), .phase(phase), .ctl_on(ctl_on), .sw_off(sw_off),
      .art_pres(art_pres));
   lce_bus_model lce_bus_model_i (.mclk(mclk), .presence(presence),
      .bright(bright), .fb_bright(fb_bright), .dis_valid(dis_valid),
      .dis_value(dis_value), .so_tel(so_tel));
   // ************************************************
   // clock, reset, timeout
   // ************************************************
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // generous ceiling: whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // ************************************************
   // tasks
   // ************************************************
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer; held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   // read, compare masked data and the error flag
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp, input logic experr);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q & m, exp);
      chk({31'h0, e}, {31'h0, experr});
   endtask : rd
   // bounded wait for a phase, then compare it
   task automatic wait_ph(input logic [2:0] p, input int n);
      for (int k = 0; k < n && phase !== p; k++) begin
         @(posedge mclk);
         #1;
      end
      chk({29'h0, phase}, {29'h0, p});
   endtask : wait_ph
   // phase must not move for n cycles
   task automatic hold_ph(input logic [2:0] p, input int n);
      int bad;
      bad = 0;
      repeat (n) begin
         @(posedge mclk);
         #1;
         if (phase !== p) bad++;
      end
      chk(32'(bad), 32'h0);
   endtask : hold_ph
   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      rstn    = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      // registers, unmapped address, feedback readback
      rd(ADDR_CFG, 32'hf, 32'h0, 1'b0);
      rd(ADDR_SETPT, 32'hff, 32'h80, 1'b0);
      rd(8'h0c, 32'hffffffff, 32'h0, 1'b1);
      wr(ADDR_SETPT, 32'h40);
      rd(ADDR_SETPT, 32'hff, 32'h40, 1'b0);
      lce_bus_model_i.set_env(1'b1, 8'h10, 8'h5a);
      rd(ADDR_STAT, 32'hff0000, 32'h5a0000, 1'b0);
      $display("test registers done");
      // switch-off end mode
      wait_ph(3'd1, 8);
      wr(ADDR_CFG, {30'h0, END_SWOFF});
      lce_bus_model_i.send_dis(1'b1);
      wait_ph(3'd4, 3);
      lce_bus_model_i.send_dis(1'b0);
      #1;
      chk({31'h0, sw_off}, 32'h1);
      chk({29'h0, phase}, 32'h0);
      wait_ph(3'd1, 3);
      $display("test switch off done");
      // step-down aborted, no-telegram end mode
      lce_bus_model_i.set_env(1'b1, 8'hc0, 8'hc0);
      wait_ph(3'd2, 60);
      lce_bus_model_i.set_env(1'b0, 8'hc0, 8'hc0);
      wait_ph(3'd3, 8);
      wr(ADDR_CFG, {30'h0, END_NOTEL});
      lce_bus_model_i.send_dis(1'b1);
      wait_ph(3'd4, 3);
      lce_bus_model_i.set_env(1'b1, 8'hc0, 8'hc0);
      repeat (5) @(posedge mclk);
      lce_bus_model_i.send_dis(1'b0);
      #1;
      chk({29'h0, phase}, 32'h0);
      chk({31'h0, sw_off}, 32'h0);
      hold_ph(3'd0, 10);
      lce_bus_model_i.set_env(1'b0, 8'hc0, 8'hc0);
      repeat (5) @(posedge mclk);
      lce_bus_model_i.set_env(1'b1, 8'hc0, 8'hc0);
      wait_ph(3'd2, 8);
      $display("test no telegram done");
      // startup end mode with artificial presence
      wr(ADDR_CFG, {30'h0, END_START});
      lce_bus_model_i.send_dis(1'b1);
      wait_ph(3'd4, 3);
      lce_bus_model_i.set_env(1'b0, 8'h10, 8'h00);
      repeat (5) @(posedge mclk);
      lce_bus_model_i.send_dis(1'b0);
      #1;
      chk({31'h0, art_pres}, 32'h1);
      wait_ph(3'd1, 3);
      wait_ph(3'd2, 60);
      chk({31'h0, art_pres}, 32'h0);
      wait_ph(3'd3, 5);
      wait_ph(3'd0, 110);
      $display("test startup done");
      // superimposed operation not allowed
      lce_bus_model_i.set_env(1'b1, 8'hc0, 8'hc0);
      wait_ph(3'd2, 8);
      chk({31'h0, ctl_on}, 32'h1);
      wr(ADDR_CFG, 32'h1);
      lce_bus_model_i.send_so(0);
      hold_ph(3'd2, 5);
      rd(ADDR_STAT, 32'hf20, 32'h0, 1'b0);
      // each listening input, ended only by the disabling input
      wr(ADDR_CFG, 32'hd);
      for (i = 0; i < SO_NUM; i++) begin
         lce_bus_model_i.send_so(i);
         wait_ph(3'd4, 3);
         chk({31'h0, ctl_on}, 32'h0);
         rd(ADDR_STAT, 32'hf20, 32'h20 | (32'h100 << i), 1'b0);
         lce_bus_model_i.set_env(1'b0, 8'hc0, 8'hc0);
         hold_ph(3'd4, 8);
         lce_bus_model_i.set_env(1'b1, 8'hc0, 8'hc0);
         wr(ADDR_STAT, 32'hf00);
         lce_bus_model_i.send_dis(1'b0);
         wait_ph(3'd2, 8);
      end
      // automatic end at the end of presence
      wr(ADDR_CFG, 32'h5);
      lce_bus_model_i.send_so(1);
      wait_ph(3'd4, 3);
      lce_bus_model_i.set_env(1'b0, 8'hc0, 8'hc0);
      wait_ph(3'd3, 6);
      // spare mode code behaves as no telegram: standing presence is not new
      wr(ADDR_CFG, 32'h3);
      lce_bus_model_i.set_env(1'b1, 8'hc0, 8'hc0);
      lce_bus_model_i.send_dis(1'b1);
      wait_ph(3'd4, 3);
      lce_bus_model_i.send_dis(1'b0);
      #1;
      chk({29'h0, phase}, 32'h0);
      chk({31'h0, ctl_on}, 32'h0);
      hold_ph(3'd0, 8);
      $display("test superimposed done");
      tally_and_finish();
   end
endmodule : light_control_enable_override_bench
`default_nettype wire
